// ---- src/spc_regs.vh ----
// register offsets, field positions and reset values for the status pin and pad config block
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

`define SPC_OFS_IO_PAD_CONFIG 8'h00
`define SPC_OFS_STATUS_PIN_CONFIG 8'h01
`define SPC_OFS_GPIO_STATUS 8'h02

`define SPC_IO_RESET 8'h2F
`define SPC_IO_WMASK 8'hFF
`define SPC_STS_RESET 16'h0200
`define SPC_STS_WMASK 16'h1F1F

`define SPC_GATE_HI 7
`define SPC_GATE_LO 6
`define SPC_PPDRV_HI 5
`define SPC_PPDRV_LO 4
`define SPC_ODDRV_HI 3
`define SPC_ODDRV_LO 2
`define SPC_DATAPU_BIT 1
`define SPC_CLKPU_BIT 0

`define SPC_OD_BIT 12
`define SPC_HIZ_BIT 11
`define SPC_PD_BIT 10
`define SPC_PU_BIT 9
`define SPC_POL_BIT 8
`define SPC_SEL_HI 4
`define SPC_SEL_LO 0

`define SPC_GATE_APLL 2'h0
`define SPC_GATE_DPLL 2'h1
`define SPC_GATE_NONE 2'h2

`define SPC_SEL_APLL 5'h00
`define SPC_SEL_DPLL 5'h01
`define SPC_SEL_LOS0 5'h02
`define SPC_SEL_LOS1 5'h03
`define SPC_SEL_LOSX 5'h04
`define SPC_SEL_ACT0 5'h05
`define SPC_SEL_ACT1 5'h06
`define SPC_SEL_INV0 5'h07
`define SPC_SEL_INV1 5'h08
`define SPC_SEL_INT 5'h09
`define SPC_SEL_READY 5'h0A
`define SPC_SEL_LOW 5'h1D
`define SPC_SEL_HIGH 5'h1E
`define SPC_SEL_NOPOL 5'h1F

`endif

// ---- src/spc_status_pin_and_pad_config.v ----
// status pin source select, pad options and startup output gating
// What this block does
// - code 0: outputs off until analog lock
// - code 1: outputs off until digital lock
// - code 2: no lock gating; 3 reserved
// - push-pull drive strength field, reset 2
// - open-drain drive strength field, reset 3
// - bit 1 enables data pad pull-up
// - bit 0 enables clock pad pull-up
// - open-drain mode only pulls low or releases
// - tristate bit floats the status pin
// - bit 10 enables status pin pull-down
// - bit 9 enables weak status pull-up
// - polarity bit inverts the selected signal
// - polarity ignored when selector is 0x1F
// - five-bit selector; 0x1D low, 0x1E high
// - codes 0-4 route lock and loss status
// - codes 5-8 route activity and invalid status
// - code 9 interrupt, code A device ready
// - readback mirrors pin for codes 0-4 only
`timescale 1ns/1ps
`include "spc_regs.vh"

module spc_status_pin_and_pad_config (
    input wire clk_sys,
    input wire rst,
    input wire regWrEn,
    input wire regRdEn,
    input wire [7:0] regAddr,
    input wire [15:0] regWrData,
    output reg [15:0] regRdData,
    input wire apllLock,
    input wire dpllLock,
    input wire signal_loss_monitor_0,
    input wire signalLossMonitor1,
    input wire signalLossMonitorXtal,
    input wire activity_monitor_0,
    input wire activityMonitor1,
    input wire refInvalid0,
    input wire refInvalid1,
    input wire [7:0] deviceIntStatus,
    input wire [7:0] deviceIntEnable,
    input wire startupActive,
    input wire startupDone,
    output reg clockOutputsEnable,
    output reg statusPinOut,
    output reg statusPinOe_n,
    output wire status_pin_pullup_en,
    output wire status_pin_pulldown_en,
    output wire [1:0] push_pull_drive_strength,
    output wire [1:0] open_drain_drive_strength,
    output wire data_pad_pullup_en,
    output wire clock_pad_pullup_en
);

    // status inputs come from other clock domains, so each passes two flops first
    localparam NSYNC = 10;
    reg [NSYNC-1:0] syncA_r;
    reg [NSYNC-1:0] syncB_r;
    // interrupt vectors are synchronised bit by bit before they are combined
    reg [7:0] intStsA_r;
    reg [7:0] intStsB_r;
    reg [7:0] intEnA_r;
    reg [7:0] intEnB_r;
    reg [7:0] ioCfg_r;
    reg [15:0] pinCfg_r;
    reg [4:0] srcSel;
    reg srcVal;
    reg pinVal;
    reg gateOff;
    wire sApll;
    wire sDpll;
    wire sIntAny;
    wire [NSYNC-1:0] rawIn;

    assign rawIn = {startupDone, refInvalid1, refInvalid0,
        activityMonitor1, activity_monitor_0, signalLossMonitorXtal, signalLossMonitor1,
        signal_loss_monitor_0, dpllLock, apllLock};

    always @(posedge clk_sys) begin
        if (rst) begin
            syncA_r <= {NSYNC{1'b0}};
            syncB_r <= {NSYNC{1'b0}};
            intStsA_r <= 8'h00;
            intStsB_r <= 8'h00;
            intEnA_r <= 8'h00;
            intEnB_r <= 8'h00;
        end else begin
            syncA_r <= rawIn;
            syncB_r <= syncA_r;
            intStsA_r <= deviceIntStatus;
            intStsB_r <= intStsA_r;
            intEnA_r <= deviceIntEnable;
            intEnB_r <= intEnA_r;
        end
    end

    assign sApll = syncB_r[0];
    assign sDpll = syncB_r[1];
    assign sIntAny = |(intStsB_r & intEnB_r);

    // register writes; reserved bits are masked off so they hold zero
    always @(posedge clk_sys) begin
        if (rst) begin
            ioCfg_r <= `SPC_IO_RESET;
            pinCfg_r <= `SPC_STS_RESET;
        end else if (regWrEn) begin
            if (regAddr == `SPC_OFS_IO_PAD_CONFIG)
                ioCfg_r <= regWrData[7:0] & `SPC_IO_WMASK;
            if (regAddr == `SPC_OFS_STATUS_PIN_CONFIG)
                pinCfg_r <= regWrData & `SPC_STS_WMASK;
        end
    end

    assign push_pull_drive_strength = ioCfg_r[`SPC_PPDRV_HI:`SPC_PPDRV_LO];
    assign open_drain_drive_strength = ioCfg_r[`SPC_ODDRV_HI:`SPC_ODDRV_LO];
    assign data_pad_pullup_en = ioCfg_r[`SPC_DATAPU_BIT];
    assign clock_pad_pullup_en = ioCfg_r[`SPC_CLKPU_BIT];
    assign status_pin_pulldown_en = pinCfg_r[`SPC_PD_BIT];
    assign status_pin_pullup_en = pinCfg_r[`SPC_PU_BIT];

    // source selection; reserved codes select zero, which the polarity bit inverts
    always @* begin
        srcSel = pinCfg_r[`SPC_SEL_HI:`SPC_SEL_LO];
        case (srcSel)
            `SPC_SEL_APLL: srcVal = sApll;
            `SPC_SEL_DPLL: srcVal = sDpll;
            `SPC_SEL_LOS0: srcVal = syncB_r[2];
            `SPC_SEL_LOS1: srcVal = syncB_r[3];
            `SPC_SEL_LOSX: srcVal = syncB_r[4];
            `SPC_SEL_ACT0: srcVal = syncB_r[5];
            `SPC_SEL_ACT1: srcVal = syncB_r[6];
            `SPC_SEL_INV0: srcVal = syncB_r[7];
            `SPC_SEL_INV1: srcVal = syncB_r[8];
            `SPC_SEL_INT: srcVal = sIntAny;
            `SPC_SEL_READY: srcVal = syncB_r[9];
            `SPC_SEL_LOW: srcVal = 1'b0;
            `SPC_SEL_HIGH: srcVal = 1'b1;
            default: srcVal = 1'b0;
        endcase
        if (pinCfg_r[`SPC_POL_BIT] && srcSel != `SPC_SEL_NOPOL)
            pinVal = ~srcVal;
        else
            pinVal = srcVal;
        // startup gating: outputs stay off while startup runs and chosen lock is low
        case (ioCfg_r[`SPC_GATE_HI:`SPC_GATE_LO])
            `SPC_GATE_APLL: gateOff = startupActive && !sApll;
            `SPC_GATE_DPLL: gateOff = startupActive && !sDpll;
            `SPC_GATE_NONE: gateOff = 1'b0;
            default: gateOff = 1'b0;
        endcase
    end

    // pin drive from flops; open-drain only ever drives a zero
    always @(posedge clk_sys) begin
        if (rst) begin
            statusPinOut <= 1'b0;
            statusPinOe_n <= 1'b1;
            clockOutputsEnable <= 1'b0;
        end else begin
            clockOutputsEnable <= ~gateOff;
            if (pinCfg_r[`SPC_HIZ_BIT]) begin
                statusPinOut <= 1'b0;
                statusPinOe_n <= 1'b1;
            end else if (pinCfg_r[`SPC_OD_BIT]) begin
                statusPinOut <= 1'b0;
                statusPinOe_n <= pinVal;
            end else begin
                statusPinOut <= pinVal;
                statusPinOe_n <= 1'b0;
            end
        end
    end

    // register read port
    always @(posedge clk_sys) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (regRdEn) begin
            case (regAddr)
                `SPC_OFS_IO_PAD_CONFIG: regRdData <= {8'h00, ioCfg_r};
                `SPC_OFS_STATUS_PIN_CONFIG: regRdData <= pinCfg_r;
                `SPC_OFS_GPIO_STATUS:
                    regRdData <= {14'h0000, (srcSel <= `SPC_SEL_LOSX) & pinVal, 1'b0};
                default: regRdData <= 16'h0000;
            endcase
        end
    end

endmodule

// ---- verif/spc_pin_board.sv ----
// board side of the status pin: resolves the pad level seen by the host
`timescale 1ns/1ps
module spc_pin_board (
    input wire drv,
    input wire oeN,
    input wire pu,
    input wire pd,
    output wire level
);
    // a released pin never shows its last value: on-chip pulls, else the board pull-up
    assign level = !oeN ? drv : (pu | !pd);
endmodule

// ---- verif/spc_checker.sv ----
// assertions on the status pin and pad config ports
`timescale 1ns/1ps
module spc_checker (
    input logic clk_sys, rst, regWrEn, apllLock, dpllLock, startupActive,
    input logic [7:0] regAddr,
    input logic [15:0] regWrData,
    input logic clockOutputsEnable, statusPinOut, statusPinOe_n, status_pin_pullup_en,
    input logic status_pin_pulldown_en, data_pad_pullup_en, clock_pad_pullup_en,
    input logic [1:0] push_pull_drive_strength, open_drain_drive_strength
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [1:0] gate_r;
    wire pinWr = regWrEn && regAddr == 8'h01;
    wire [15:0] d = regWrData;
    // shadow of the gating field so gating can be judged without seeing the body
    always @(posedge clk_sys) begin
        if (rst)
            gate_r <= 2'h0;
        else if (regWrEn && regAddr == 8'h00)
            gate_r <= regWrData[7:6];
    end
    property p_rstPads;
        $fell(rst) |-> status_pin_pullup_en && data_pad_pullup_en && clock_pad_pullup_en
            && push_pull_drive_strength == 2'h2 && open_drain_drive_strength == 2'h3;
    endproperty
    a_rstPads: assert property (p_rstPads) else $error("pad reset value");
    property p_hiz;
        pinWr && d[11] ##1 !pinWr |-> ##1 statusPinOe_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pin not floated");
    property p_od;
        pinWr && d[12] && !d[11] ##1 !pinWr |-> ##1 !statusPinOut;
    endproperty
    a_od: assert property (p_od) else $error("open drain drove high");
    property p_low;
        pinWr && d[12:11] == 2'h0 && d[4:0] == 5'h1D ##1 !pinWr
            |-> ##1 !statusPinOe_n && statusPinOut == $past(regWrData[8], 2);
    endproperty
    a_low: assert property (p_low) else $error("constant low wrong");
    property p_noPol;
        pinWr && d[8] && d[4:0] == 5'h1F ##1 !pinWr |-> ##1 !statusPinOut;
    endproperty
    a_noPol: assert property (p_noPol) else $error("polarity not ignored");
    property p_pd;
        pinWr |=> status_pin_pulldown_en == $past(regWrData[10]);
    endproperty
    a_pd: assert property (p_pd) else $error("pull-down enable wrong");
    property p_gateA;
        (gate_r == 2'h0 && startupActive && !apllLock) [*4] |=> !clockOutputsEnable;
    endproperty
    a_gateA: assert property (p_gateA) else $error("outputs on before analog lock");
    property p_gateD;
        (gate_r == 2'h1 && startupActive && !dpllLock) [*4] |=> !clockOutputsEnable;
    endproperty
    a_gateD: assert property (p_gateD) else $error("outputs on before digital lock");
    property p_gateN;
        (gate_r == 2'h2) [*2] |=> clockOutputsEnable;
    endproperty
    a_gateN: assert property (p_gateN) else $error("outputs held off");
    c_gateD: cover property (gate_r == 2'h1 && clockOutputsEnable);
    c_od: cover property (pinWr && d[12]);
    c_noPol: cover property (pinWr && d[4:0] == 5'h1F);
endmodule

// ---- verif/spc_tb_top.sv ----
// testbench for the status pin and pad config block
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 0, rst = 1, regWrEn = 0, regRdEn = 0, startupActive = 1, level;
    logic [7:0] regAddr = 0;
    logic [15:0] regWrData = 0, regRdData;
    logic [10:0] src = 0;
    logic clockOutputsEnable, statusPinOut, statusPinOe_n, status_pin_pullup_en;
    logic status_pin_pulldown_en, data_pad_pullup_en, clock_pad_pullup_en;
    logic [1:0] push_pull_drive_strength, open_drain_drive_strength;
    int nFail = 0, testsRun = 0;
    spc_status_pin_and_pad_config spc_status_pin_and_pad_config_i (.*, .apllLock(src[0]),
        .dpllLock(src[1]), .signal_loss_monitor_0(src[2]), .signalLossMonitor1(src[3]),
        .signalLossMonitorXtal(src[4]), .activity_monitor_0(src[5]),
        .activityMonitor1(src[6]), .refInvalid0(src[7]), .refInvalid1(src[8]),
        .deviceIntStatus({2'h0, src[9], 5'h1}), .deviceIntEnable(8'h20),
        .startupDone(src[10]));
    spc_pin_board spc_pin_board_i (.drv(statusPinOut), .oeN(statusPinOe_n),
        .pu(status_pin_pullup_en), .pd(status_pin_pulldown_en), .level(level));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        testsRun++;
        if (g !== e) begin
            nFail++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        regWrEn <= 1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWrEn <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        regRdEn <= 1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdEn <= 0;
        #1 chk("read", e, regRdData);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // far more than the sequence needs, so only a hang gets here
    initial begin
        repeat (5000) @(posedge clk_sys);
        nFail++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 0;
        rdc(8'h00, 16'h002F);
        rdc(8'h01, 16'h0200);
        rdc(8'h03, 16'h0000);
        wr(8'h01, 16'hFFFF);
        rdc(8'h01, 16'h1F1F);
        wr(8'h00, 16'h005C);
        rdc(8'h00, 16'h005C);
        chk("pads", 16'h001C, {push_pull_drive_strength, open_drain_drive_strength,
            data_pad_pullup_en, clock_pad_pullup_en});
        for (int g = 0; g < 3; g++) begin
            @(posedge clk_sys) src <= 0;
            wr(8'h00, {8'h00, 2'(g), 6'h23});
            cyc(4);
            chk("gate", 16'(g == 2), clockOutputsEnable);
            @(posedge clk_sys) src[g % 2] <= 1;
            cyc(4);
            chk("gate", 1, clockOutputsEnable);
        end
        for (int c = 0; c < 31; c++)
            for (int k = 0; k < 4; k++)
                if (c < 11 || c > 28) begin
                    wr(8'h01, 16'((k / 2) * 256 + c));
                    @(posedge clk_sys) src <= 11'(k % 2) << c;
                    cyc(4);
                    chk("pin", 16'(((c == 30) | (c < 11 && k % 2)) ^ (k / 2)),
                        {statusPinOe_n, statusPinOut});
                    rdc(8'h02, (c < 5) ? 16'(((k % 2) ^ (k / 2)) * 2) : 16'h0);
                end
        wr(8'h01, 16'h121E);
        cyc(2);
        chk("odRelease", 1, {statusPinOut, level});
        wr(8'h01, 16'h131E);
        cyc(2);
        chk("odLow", 0, {statusPinOe_n, level});
        wr(8'h01, 16'h0C1E);
        cyc(2);
        chk("hiz", 5, {statusPinOe_n, level, status_pin_pulldown_en});
        wr(8'h01, 16'h011F);
        cyc(2);
        chk("noPol", 0, {statusPinOe_n, statusPinOut});
        tally_and_finish();
    end
endmodule
bind spc_status_pin_and_pad_config spc_checker spc_checker_i (.*);
